// file: hw/dbd_consts.svh
// Constants for the dead-battery probe sequencer.
// Assumes a 200 MHz clock; times are given in microseconds.
`ifndef DBD_CONSTS_SVH
`define DBD_CONSTS_SVH
`define DBD_CLK_MHZ 200
`define DBD_PROBE_INTERVAL_US 50
`define DBD_STREAM_WAIT_US 20
`define DBD_SINK_READY_US 50
`define DBD_DISCHARGE_US 10
`define DBD_SOURCE_OFF_US 20
`define DBD_STREAM_BITS 128
`define DBD_CNT_W 24
`define DBD_BIT_W 8
`endif

// file: hw/dbd_pkg.sv
// Types for the dead-battery probe sequencer.
// Assumes dbd_consts.svh is included by the design module.
package dbd_pkg;
	typedef enum logic [2:0] {
		ST_WAIT   = 3'b000,
		ST_PROBE  = 3'b001,
		ST_FULL   = 3'b010,
		ST_DISCH  = 3'b011,
		ST_OFF    = 3'b100,
		ST_SOURCE = 3'b101
	} dbd_state_t;
	typedef struct packed {
		logic probe_en;
		logic full_en;
		logic disch_en;
	} dbd_enables_t;
endpackage

// file: hw/dbd_seq.sv
// Dead-battery probe sequencer on the supplying port.
// Assumes synchronous inputs from the VBUS comparators and the receiver.
//
// What this block does
// - Probe VBUS periodically while VBUS is not above safe zero level
// - Detected stream switches VBUS to full supply
// - No stream means never full supply
// - Unanswered probe repeats the cycle
// - Probe current and duration are bounded
// - Other presence detection may gate probing
// - Supplying port always implements this detection
// - First step starts probe interval timer
// - Completion leaves us source, partner sink
// - Need 128 alternating bits for detection
// - On expiry probe, start stream wait timer
// - Timeout: discharge bounded, off interval, restart
// - Sink ready timer expiry discharges and restarts
`timescale 1ns/1ps
`include "dbd_consts.svh"
module dbd_seq
	import dbd_pkg::*;
(
	input wire logic clk, // 200 MHz clock
	input wire logic resetn, // Async reset, active low
	input wire logic vbus_full_i, // VBUS at full supply level
	input wire logic vbus_above_zero_i, // VBUS above safe zero level
	input wire logic stream_bit_i, // Receiver bit stream sample
	input wire logic stream_bit_vld_i, // Pulse: new stream bit
	input wire logic partner_ok_i, // Optional presence detect, tie high
	output logic probe_en_q, // Current-limited probe supply on
	output logic full_en_q, // Full supply on
	output logic disch_en_q, // Discharge path on
	output logic stream_det_q, // Bit stream declared present
	output logic sourcing_q // Acting as source after swap
);
	localparam int unsigned CYC_US = `DBD_CLK_MHZ;
	localparam logic [`DBD_CNT_W-1:0] PROBE_CYC =
		`DBD_CNT_W'(`DBD_PROBE_INTERVAL_US * CYC_US);
	localparam logic [`DBD_CNT_W-1:0] WAIT_CYC =
		`DBD_CNT_W'(`DBD_STREAM_WAIT_US * CYC_US);
	localparam logic [`DBD_CNT_W-1:0] READY_CYC =
		`DBD_CNT_W'(`DBD_SINK_READY_US * CYC_US);
	localparam logic [`DBD_CNT_W-1:0] DISCH_CYC =
		`DBD_CNT_W'(`DBD_DISCHARGE_US * CYC_US);
	localparam logic [`DBD_CNT_W-1:0] OFF_CYC =
		`DBD_CNT_W'(`DBD_SOURCE_OFF_US * CYC_US);
	localparam logic [`DBD_BIT_W-1:0] NEED_BITS =
		`DBD_BIT_W'(`DBD_STREAM_BITS - 1);

	dbd_state_t state_q, state_d;
	logic [`DBD_CNT_W-1:0] tmr_q, tmr_d;
	logic [`DBD_BIT_W-1:0] bits_q, bits_d;
	logic last_bit_q, last_bit_d;
	logic det_d, src_d;
	dbd_enables_t en_d;

	function automatic dbd_enables_t enables(input dbd_state_t s);
		dbd_enables_t e;
		e = '0;
		e.probe_en = (s == ST_PROBE);
		e.full_en = (s == ST_FULL) || (s == ST_SOURCE);
		e.disch_en = (s == ST_DISCH);
		return e;
	endfunction

	// Stream detector: counts consecutive alternating bits
	always_comb begin
		bits_d = bits_q;
		last_bit_d = last_bit_q;
		det_d = stream_det_q;
		if (state_q != ST_PROBE) begin
			bits_d = '0;
			det_d = 1'b0;
		end else if (stream_bit_vld_i) begin
			last_bit_d = stream_bit_i;
			if (bits_q == '0 || stream_bit_i != last_bit_q) begin
				if (bits_q == NEED_BITS) begin
					det_d = 1'b1;
				end else begin
					bits_d = bits_q + 1'b1;
				end
			end else begin
				bits_d = `DBD_BIT_W'(1); // Repeat restarts run
			end
		end
	end

	// Quiet detector for the stream stop in ST_FULL
	logic [`DBD_BIT_W-1:0] idle_q, idle_d;
	logic stream_idle;
	assign stream_idle = (idle_q == NEED_BITS);
	always_comb begin
		idle_d = idle_q;
		if (state_q != ST_FULL || stream_bit_vld_i) begin
			idle_d = '0;
		end else if (!stream_idle) begin
			idle_d = idle_q + 1'b1;
		end
	end

	always_comb begin
		state_d = state_q;
		tmr_d = (tmr_q == '0) ? tmr_q : tmr_q - 1'b1;
		src_d = sourcing_q;
		unique case (state_q)
			ST_WAIT: begin
				// Partner supplying or gated off: hold, restart timer
				if (vbus_full_i || vbus_above_zero_i || !partner_ok_i) begin
					tmr_d = PROBE_CYC;
				end else if (tmr_q == '0) begin
					state_d = ST_PROBE;
					tmr_d = WAIT_CYC;
				end
			end
			ST_PROBE: begin
				if (stream_det_q) begin
					state_d = ST_FULL;
					tmr_d = READY_CYC;
				end else if (tmr_q == '0) begin
					state_d = ST_DISCH;
					tmr_d = DISCH_CYC;
				end
			end
			ST_FULL: begin
				// Partner signals ready by going quiet
				if (!stream_bit_vld_i && tmr_q != '0 && stream_idle) begin
					state_d = ST_SOURCE;
					src_d = 1'b1;
				end else if (tmr_q == '0) begin
					state_d = ST_DISCH;
					tmr_d = DISCH_CYC;
				end
			end
			ST_DISCH: begin
				if (tmr_q == '0) begin
					state_d = ST_OFF;
					tmr_d = OFF_CYC - DISCH_CYC;
				end
			end
			ST_OFF: begin
				if (tmr_q == '0) begin
					state_d = ST_WAIT;
					tmr_d = PROBE_CYC;
				end
			end
			ST_SOURCE: begin
				// Hold as source; PD layer takes over from here
			end
			default: begin
				state_d = ST_WAIT;
				tmr_d = PROBE_CYC;
			end
		endcase
		en_d = enables(state_d);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_WAIT;
			tmr_q <= PROBE_CYC;
			bits_q <= '0;
			last_bit_q <= 1'b0;
			idle_q <= '0;
			stream_det_q <= 1'b0;
			sourcing_q <= 1'b0;
			probe_en_q <= 1'b0;
			full_en_q <= 1'b0;
			disch_en_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tmr_q <= tmr_d;
			bits_q <= bits_d;
			last_bit_q <= last_bit_d;
			idle_q <= idle_d;
			stream_det_q <= det_d;
			sourcing_q <= src_d;
			probe_en_q <= en_d.probe_en;
			full_en_q <= en_d.full_en;
			disch_en_q <= en_d.disch_en;
		end
	end

	a_enables_exclusive: assert property (@(posedge clk) disable iff (!resetn)
		$onehot0({probe_en_q, full_en_q, disch_en_q}))
		else $error("supply enables overlap");
	a_full_needs_stream: assert property (@(posedge clk) disable iff (!resetn)
		$rose(full_en_q) |-> $past(stream_det_q))
		else $error("full supply without stream");
	a_probe_after_wait: assert property (@(posedge clk) disable iff (!resetn)
		$rose(probe_en_q) |-> $past(state_q, 2) == ST_WAIT)
		else $error("probe not after interval");
	a_probe_bounded: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_PROBE && tmr_q == '0 && !stream_det_q
		|=> state_q == ST_DISCH)
		else $error("probe not ended on timeout");
	a_disch_to_off: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_DISCH && tmr_q == '0 |=> state_q == ST_OFF ##1 !disch_en_q)
		else $error("discharge not stopped");
	a_ready_timeout: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_FULL && tmr_q == '0 |=> state_q != ST_FULL)
		else $error("sink ready timeout ignored");
	a_detect_in_probe: assert property (@(posedge clk) disable iff (!resetn)
		stream_det_q |-> $past(state_q) == ST_PROBE)
		else $error("detect outside probe");
	a_wait_held: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_WAIT && vbus_above_zero_i |=> state_q == ST_WAIT)
		else $error("probed while vbus present");
endmodule // dbd_seq

// file: hw/dbd_unused_placeholder_removed.sv
`timescale 1ns/1ps

// file: sim/dbd_partner.sv
// Partner port model: answers the probe with alternating bits.
// Assumes the sequencer's supply enables on the same clock.
`timescale 1ns/1ps
module dbd_partner (
	input wire logic clk, // Clock
	input wire logic answer, // Partner wants power
	input wire logic hold, // Never signal ready, keep streaming
	input wire logic probe_en, // Probe supply seen
	input wire logic full_en, // Full supply seen
	output logic bit_o, // Stream bit
	output logic vld_o // Stream bit pulse
);
	int n = 0;
	initial begin
		bit_o = 1'b0;
		vld_o = 1'b0;
	end
	// Bit toggles every cycle, so an idle line never shows a stale value
	always @(posedge clk) begin
		bit_o <= #1 ~bit_o;
		vld_o <= #1 answer &&
			(probe_en || (full_en && (hold || n < 200)));
		if (full_en) n <= n + 1;
	end
endmodule // dbd_partner

// file: sim/dbd_seq_tb.sv
// Bench for the dead-battery probe sequencer.
// Assumes the fixed timer counts at 200 MHz, so the run is long.
`timescale 1ns/1ps
module dbd_seq_tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic answer = 1'b0;
	logic hold = 1'b0;
	logic vfull = 1'b0;
	logic vzero = 1'b0;
	logic sbit, svld, probe, full, disch, det, src;
	int n_mismatch = 0;
	int checks_done = 0;
	int cyc = 0;
	int i;
	initial begin
		forever #2.5 clk = ~clk;
	end
	dbd_seq i_dut (.clk(clk), .resetn(resetn), .vbus_full_i(vfull),
		.vbus_above_zero_i(vzero), .stream_bit_i(sbit),
		.stream_bit_vld_i(svld), .partner_ok_i(1'b1), .probe_en_q(probe),
		.full_en_q(full), .disch_en_q(disch), .stream_det_q(det),
		.sourcing_q(src));
	dbd_partner i_partner (.clk(clk), .answer(answer), .hold(hold),
		.probe_en(probe),
		.full_en(full), .bit_o(sbit), .vld_o(svld));
	task automatic chk(input logic got, input logic exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	task end_sim();
		$display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Partner never drives VBUS; it follows our own supplies only
	always @(posedge clk) begin
		cyc++;
		vfull <= #1 full;
		vzero <= #1 probe | full;
		if (cyc == 60000) begin
			n_mismatch++;
			end_sim();
		end
	end
	// Looked at mid-cycle, where registered outputs have settled
	always @(negedge clk) begin
		if (resetn) chk(probe & full, 1'b0, "supplies overlap");
	end
	task t_reset();
		chk(probe | full | disch | det | src, 1'b0, "reset outputs");
		$display("t_reset done");
	endtask
	task t_unanswered();
		for (i = 0; i < 10010 && probe !== 1'b1; i++) @(negedge clk);
		chk(i > 9990, 1'b1, "probe interval");
		for (i = 0; i < 4010 && disch !== 1'b1; i++) begin
			@(negedge clk);
			chk(full, 1'b0, "full without stream");
		end
		chk(i > 3990, 1'b1, "stream wait");
		chk(probe, 1'b0, "probe dropped");
		for (i = 0; i < 2010 && disch === 1'b1; i++) @(negedge clk);
		chk(i > 1990 && i < 2010, 1'b1, "discharge time");
		$display("t_unanswered done");
	endtask
	task t_answered();
		@(posedge clk);
		#1 answer = 1'b1;
		for (i = 0; i < 12100 && probe !== 1'b1; i++) @(negedge clk);
		chk(i > 11900, 1'b1, "probe repeated");
		for (i = 0; i < 200 && det !== 1'b1; i++) @(negedge clk);
		chk(i >= 128 && i < 140, 1'b1, "detect after 128 bits");
		@(negedge clk);
		chk(full & ~probe, 1'b1, "full supply");
		for (i = 0; i < 600 && src !== 1'b1; i++) @(negedge clk);
		chk(src & full & ~disch, 1'b1, "sourcing");
		$display("t_answered done");
	endtask
	// Partner never goes quiet, so the sink ready timer must expire
	task t_ready_timeout();
		@(posedge clk);
		#1 resetn = 1'b0;
		hold = 1'b1;
		@(posedge clk);
		#1 chk(probe | full | disch | det | src, 1'b0, "mid reset");
		@(posedge clk);
		#1 resetn = 1'b1;
		for (i = 0; i < 10200 && full !== 1'b1; i++) @(negedge clk);
		chk(full, 1'b1, "full after stream");
		for (i = 0; i < 10010 && disch !== 1'b1; i++) begin
			@(negedge clk);
			chk(src, 1'b0, "sourcing without ready");
		end
		chk(i > 9990, 1'b1, "sink ready timeout");
		chk(full, 1'b0, "full dropped on timeout");
		$display("t_ready_timeout done");
	endtask
	initial begin
		repeat (15) @(negedge clk);
		t_reset();
		@(posedge clk);
		#1 resetn = 1'b1;
		t_unanswered();
		t_answered();
		t_ready_timeout();
		end_sim();
	end
endmodule // dbd_seq_tb
